// file: hw/sfepic_pkg.sv
/*
  Shared constants for the serial-flash erase, power-down and identification
  command path: instruction codes, status byte layout and timing counts.
  Assumes a single system clock of 250 MHz on both ends of the link.
*/
package sfepic_pkg;

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000; // 250 MHz system clock.

  // ****************************************************************
  // Instruction codes
  // ****************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_ERASE_ALL_A   = 8'hC7;
  localparam logic [7:0] OP_ERASE_ALL_B   = 8'h60;
  localparam logic [7:0] OP_SLEEP         = 8'hB9;
  localparam logic [7:0] OP_WAKE_IDENT    = 8'hAB;
  localparam logic [7:0] OP_MFR_DEV_ID    = 8'h90;
  localparam logic [7:0] OP_UNIQUE_ID     = 8'h4B;
  localparam logic [7:0] OP_STD_IDENT     = 8'h9F;

  // ****************************************************************
  // Frame layout, in serial bits received before the answer starts
  // ****************************************************************
  localparam logic [6:0] OPCODE_BITS    = 7'h08; // Opcode alone.
  localparam logic [6:0] ADDR_END_BITS  = 7'h20; // Opcode plus three bytes.
  localparam logic [6:0] UNIQ_END_BITS  = 7'h28; // Opcode plus four bytes.
  localparam logic [6:0] NO_ANSWER_BITS = 7'h7F; // Never reached in practice.

  // ****************************************************************
  // Status byte layout and reset values
  // ****************************************************************
  localparam int unsigned STAT_BUSY_POS = 0;
  localparam int unsigned STAT_WEL_POS  = 1;
  localparam int unsigned STAT_BP_POS   = 2;
  localparam logic        WEL_RESET     = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned FULL_ERASE_DURATION_MS = 8;    // Erase length.
  localparam int unsigned SLEEP_ENTRY_TIME_NS    = 3000; // Longest entry time.
  localparam int unsigned WAKE_TIME_NS           = 3000; // Least wake time.
  localparam int unsigned WAKE_WITH_IDENT_TIME_NS = 5000; // Least wake time after ID read.
  localparam int unsigned HOST_GAP_NS            = 100;  // Least deselect time.

  // Cycle counts: entry time rounds down, least times round up.
  // Cycles per millisecond first, so the product stays inside 32 bits.
  localparam int unsigned ERASE_CYCLES = FULL_ERASE_DURATION_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned SLEEP_CYCLES = (SLEEP_ENTRY_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYCLES  = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_ID_CYCLES = (WAKE_WITH_IDENT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GAP_CYCLES   = (HOST_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SCLK_HALF_CYCLES = 2; // Host clock divider, half period.

  // Device operating states.
  typedef enum logic [2:0] {
    ST_IDLE        = 3'b000,
    ST_ERASE       = 3'b001,
    ST_SLEEP_ENTRY = 3'b010,
    ST_SLEEP       = 3'b011,
    ST_WAKE        = 3'b100
  } sfepic_dev_state_t;

  // Host engine states.
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SHIFT = 2'b01,
    HS_GAP   = 2'b10
  } sfepic_host_state_t;

endpackage

// file: hw/sfepic_spi_if.sv
/*
  Serial link between the host controller end and the flash device end.
  Assumes both ends run on the same system clock; the serial clock is data.
*/
`timescale 1ns/1ps
interface sfepic_spi_if;
  logic cs_n;  // Chip select, active low.
  logic sclk;  // Serial clock, idles low.
  logic mosi;  // Host to device data.
  logic miso;  // Device to host data.

  modport dev  (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// file: hw/sfepic_device.sv
/*
  Device end of the serial-flash command path: whole-array erase, sleep
  entry and wake, write enable latch, status read and identification reads.
  Assumes the link pins are synchronous to clk_sys and that each serial clock
  phase lasts at least two clk_sys cycles.

  // Function
  // - Erase needs write enable latch set.
  // - Erase only when select rises after bit eight.
  // - Valid erase starts timed full-array erase.
  // - Busy during erase; status stays readable.
  // - Erase completion clears write enable latch.
  // - Any protection bits set refuse erase.
  // - Sleep opcode exact length enters sleep.
  // - Asleep, only wake opcode is recognised.
  // - Reset comes up awake and idle.
  // - Wake opcode then select high wake time.
  // - Electronic ID after three dummies, repeating.
  // - Wake with ID read uses longer time.
  // - Wake opcode ignored while busy.
  // - Manufacturer/device bytes alternate, order by address.
  // - Unique 64-bit number after four dummies.
  // - Manufacturer, memory type, capacity bytes out.
*/
`timescale 1ns/1ps
module sfepic_device #(
  parameter int unsigned ERASE_CYCLES = sfepic_pkg::ERASE_CYCLES,
  parameter logic [7:0]  MFR_ID       = 8'h5C,                 // Arbitrary value.
  parameter logic [7:0]  DEVICE_ID    = 8'h13,                 // Arbitrary value.
  parameter logic [7:0]  MEM_TYPE     = 8'h31,                 // Arbitrary value.
  parameter logic [7:0]  CAPACITY     = 8'h14,                 // Arbitrary value.
  parameter logic [63:0] UNIQUE_ID    = 64'h0123456789ABCDEF   // Arbitrary value.
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Serial link
  sfepic_spi_if.dev        spi,
  // Array side
  input  wire logic [2:0]  block_protect_bits,
  output logic             write_enable_latch,
  output logic             busy,
  output logic             sleeping,
  output logic             erase_done
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // A zero-length erase would underflow the timer.
  if (ERASE_CYCLES < 1) begin : g_bad_erase
    $error("ERASE_CYCLES must be at least one");
  end

  localparam logic [31:0] ERASE_LOAD = 32'(ERASE_CYCLES - 1);
  localparam logic [31:0] SLEEP_LOAD = 32'(sfepic_pkg::SLEEP_CYCLES - 1);
  localparam logic [31:0] WAKE_LOAD  = 32'(sfepic_pkg::WAKE_CYCLES - 1);
  localparam logic [31:0] WAKEID_LOAD = 32'(sfepic_pkg::WAKE_ID_CYCLES - 1);

  // ****************************************************************
  // Link edge detection
  // ****************************************************************
  logic       sclk_q_reg;     // Serial clock one cycle ago.
  logic       cs_q_reg;       // Chip select one cycle ago.

  wire        sclk_rise = spi.sclk & ~sclk_q_reg & ~spi.cs_n;
  wire        sclk_fall = ~spi.sclk & sclk_q_reg & ~spi.cs_n;
  wire        cs_rise   = spi.cs_n & ~cs_q_reg;

  // ****************************************************************
  // Frame state
  // ****************************************************************
  logic [6:0] bit_cnt_reg;    // Bits received in this frame, saturating.
  logic [7:0] shift_reg;      // Incoming byte.
  logic [7:0] opcode_reg;     // Opcode of this frame.
  logic       ignore_reg;     // Frame refused at its opcode.
  logic       addr_lsb_reg;   // Last address bit, picks byte order.
  logic [5:0] out_pos_reg;    // Answer bit position.
  logic       miso_reg;       // Output data bit.

  sfepic_pkg::sfepic_dev_state_t state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic        wel_reg, wel_next;
  logic        erase_done_next;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire        op_done   = (bit_cnt_reg == sfepic_pkg::OPCODE_BITS) & sclk_rise;
  wire [7:0]  op_in     = {shift_reg[6:0], spi.mosi};
  wire        asleep    = (state_reg == sfepic_pkg::ST_SLEEP_ENTRY) | (state_reg == sfepic_pkg::ST_SLEEP);
  wire        erasing   = (state_reg == sfepic_pkg::ST_ERASE);
  wire        waking    = (state_reg == sfepic_pkg::ST_WAKE);
  wire        exact8    = (bit_cnt_reg == sfepic_pkg::OPCODE_BITS) & ~ignore_reg;
  wire        is_wake   = (opcode_reg == sfepic_pkg::OP_WAKE_IDENT);
  wire        is_erase  = (opcode_reg == sfepic_pkg::OP_ERASE_ALL_A) | (opcode_reg == sfepic_pkg::OP_ERASE_ALL_B);
  wire        protected_any = |block_protect_bits;

  // Refusal of a frame, decided when its opcode is complete.
  wire        refuse_now = waking
                         | (asleep & (op_in != sfepic_pkg::OP_WAKE_IDENT))
                         | (erasing & (op_in != sfepic_pkg::OP_READ_STATUS));

  // Bits that must arrive before the answer of each opcode begins.
  logic [6:0] resp_start;
  assign resp_start = (opcode_reg == sfepic_pkg::OP_WAKE_IDENT)  ? sfepic_pkg::ADDR_END_BITS :
                      (opcode_reg == sfepic_pkg::OP_MFR_DEV_ID)  ? sfepic_pkg::ADDR_END_BITS :
                      (opcode_reg == sfepic_pkg::OP_UNIQUE_ID)   ? sfepic_pkg::UNIQ_END_BITS :
                      (opcode_reg == sfepic_pkg::OP_STD_IDENT)   ? sfepic_pkg::OPCODE_BITS :
                      (opcode_reg == sfepic_pkg::OP_READ_STATUS) ? sfepic_pkg::OPCODE_BITS :
                                                                   sfepic_pkg::NO_ANSWER_BITS;

  // Status byte as read by the status instruction.
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[sfepic_pkg::STAT_BUSY_POS] = erasing;
    status_byte[sfepic_pkg::STAT_WEL_POS]  = wel_reg;
    status_byte[sfepic_pkg::STAT_BP_POS +: 3] = block_protect_bits;
  end

  // Answer words and the bit picked for the current position.
  wire [15:0] mfr_dev_word = addr_lsb_reg ? {DEVICE_ID, MFR_ID} : {MFR_ID, DEVICE_ID};
  wire [23:0] std_ident    = {MFR_ID, MEM_TYPE, CAPACITY};
  wire        std_in_range = (out_pos_reg < 6'h18);
  wire [4:0]  std_index    = 5'h17 - out_pos_reg[4:0];

  logic resp_bit;
  assign resp_bit = (opcode_reg == sfepic_pkg::OP_WAKE_IDENT)  ? DEVICE_ID[~out_pos_reg[2:0]] :
                    (opcode_reg == sfepic_pkg::OP_MFR_DEV_ID)  ? mfr_dev_word[~out_pos_reg[3:0]] :
                    (opcode_reg == sfepic_pkg::OP_UNIQUE_ID)   ? UNIQUE_ID[~out_pos_reg] :
                    (opcode_reg == sfepic_pkg::OP_STD_IDENT)   ? (std_in_range & std_ident[std_index]) :
                                                                 status_byte[~out_pos_reg[2:0]];

  wire answering = sclk_fall & ~ignore_reg & (bit_cnt_reg >= resp_start);

  // ****************************************************************
  // Serial frame registers
  // ****************************************************************
  // Everything frame-local clears while select is high, so a frame cut short
  // leaves nothing behind for the next one.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || spi.cs_n) begin
      bit_cnt_reg  <= 7'h00;
      shift_reg    <= 8'h00;
      opcode_reg   <= 8'h00;
      ignore_reg   <= 1'b0;
      addr_lsb_reg <= 1'b0;
      out_pos_reg  <= 6'h00;
      miso_reg     <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_reg <= op_in;
        if (bit_cnt_reg != sfepic_pkg::NO_ANSWER_BITS) begin
          bit_cnt_reg <= bit_cnt_reg + 7'h01;
        end
        if (bit_cnt_reg == sfepic_pkg::ADDR_END_BITS - 7'h01) begin
          addr_lsb_reg <= spi.mosi;
        end
      end
      if (bit_cnt_reg == sfepic_pkg::OPCODE_BITS - 7'h01 && sclk_rise) begin
        opcode_reg <= op_in;
        ignore_reg <= refuse_now;
      end
      if (answering) begin
        miso_reg    <= resp_bit;
        out_pos_reg <= out_pos_reg + 6'h01;
      end
    end
  end

  // ****************************************************************
  // Operating state, timer and write enable latch
  // ****************************************************************
  always_comb begin
    state_next      = state_reg;
    timer_next      = timer_reg;
    wel_next        = wel_reg;
    erase_done_next = 1'b0;
    case (state_reg)
      sfepic_pkg::ST_IDLE: begin
        if (cs_rise && exact8) begin
          if (is_erase && wel_reg && !protected_any) begin
            state_next = sfepic_pkg::ST_ERASE;
            timer_next = ERASE_LOAD;
          end else if (opcode_reg == sfepic_pkg::OP_SLEEP) begin
            state_next = sfepic_pkg::ST_SLEEP_ENTRY;
            timer_next = SLEEP_LOAD;
          end else if (opcode_reg == sfepic_pkg::OP_WRITE_ENABLE) begin
            wel_next = 1'b1;
          end else if (opcode_reg == sfepic_pkg::OP_WRITE_DISABLE) begin
            wel_next = 1'b0;
          end
        end
      end
      sfepic_pkg::ST_ERASE: begin
        // Status reads are served by the frame logic meanwhile.
        if (timer_reg == 32'h0) begin
          state_next      = sfepic_pkg::ST_IDLE;
          wel_next        = 1'b0;
          erase_done_next = 1'b1;
        end else begin
          timer_next = timer_reg - 32'h1;
        end
      end
      sfepic_pkg::ST_SLEEP_ENTRY, sfepic_pkg::ST_SLEEP: begin
        if (cs_rise && !ignore_reg && is_wake && bit_cnt_reg >= sfepic_pkg::OPCODE_BITS) begin
          state_next = sfepic_pkg::ST_WAKE;
          timer_next = exact8 ? WAKE_LOAD : WAKEID_LOAD;
        end else if (state_reg == sfepic_pkg::ST_SLEEP_ENTRY) begin
          if (timer_reg == 32'h0) begin
            state_next = sfepic_pkg::ST_SLEEP;
          end else begin
            timer_next = timer_reg - 32'h1;
          end
        end
      end
      sfepic_pkg::ST_WAKE: begin
        if (timer_reg == 32'h0) begin
          state_next = sfepic_pkg::ST_IDLE;
        end else begin
          timer_next = timer_reg - 32'h1;
        end
      end
      default: begin
        state_next = sfepic_pkg::ST_IDLE;
      end
    endcase
  end

  // Reset always lands awake and idle, never asleep.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg      <= sfepic_pkg::ST_IDLE;
      timer_reg      <= 32'h0;
      wel_reg        <= sfepic_pkg::WEL_RESET;
      erase_done     <= 1'b0;
      sclk_q_reg     <= 1'b0;
      cs_q_reg       <= 1'b1;
    end else begin
      state_reg      <= state_next;
      timer_reg      <= timer_next;
      wel_reg        <= wel_next;
      erase_done     <= erase_done_next;
      sclk_q_reg     <= spi.sclk;
      cs_q_reg       <= spi.cs_n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign spi.miso           = miso_reg;
  assign write_enable_latch = wel_reg;
  assign busy               = erasing;
  assign sleeping           = (state_reg == sfepic_pkg::ST_SLEEP);

endmodule

// file: hw/sfepic_host.sv
/*
  Host end of the serial-flash command path: sends an opcode and up to four
  further bytes, reads up to eight answer bytes, then holds select high.
  Assumes the device end shares clk_sys; the serial clock is made by division.
*/
`timescale 1ns/1ps
module sfepic_host #(
  parameter int unsigned HALF_CYCLES    = sfepic_pkg::SCLK_HALF_CYCLES,
  parameter int unsigned GAP_CYCLES     = sfepic_pkg::GAP_CYCLES,
  parameter int unsigned WAKE_ID_CYCLES = sfepic_pkg::WAKE_ID_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Command request
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [2:0]  cmd_tx_len,
  input  wire logic [31:0] cmd_tx_data,
  input  wire logic [3:0]  cmd_rx_len,
  // Answer
  output logic             rsp_valid,
  output logic [63:0]      rsp_data,
  // Serial link
  sfepic_spi_if.host       spi
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The device needs each clock phase to last two of its cycles.
  if (HALF_CYCLES < 2 || GAP_CYCLES < 1 || WAKE_ID_CYCLES < 1) begin : g_bad_params
    $error("HALF_CYCLES must be at least two and gaps at least one");
  end

  localparam logic [15:0] HALF_LOAD = 16'(HALF_CYCLES - 1);
  localparam logic [31:0] GAP_LOAD  = 32'(GAP_CYCLES - 1);
  localparam logic [31:0] WAKE_LOAD = 32'(WAKE_ID_CYCLES - 1);

  // ****************************************************************
  // State
  // ****************************************************************
  sfepic_pkg::sfepic_host_state_t state_reg;
  logic [15:0] div_reg;        // Serial clock phase counter.
  logic [31:0] gap_reg;        // Deselect counter.
  logic [6:0]  bits_left_reg;  // Serial bits still to send.
  logic [6:0]  rx_bits_reg;    // Bits at the end of the frame to capture.
  logic [39:0] tx_sr_reg;      // Outgoing bits, MSB first.
  logic [63:0] rx_sr_reg;      // Incoming bits.
  logic        wake_op_reg;    // Frame carried the wake opcode.
  logic        sclk_reg;
  logic        cs_n_reg;

  wire         phase_end = (div_reg == 16'h0);
  // Byte counts are kept at their own width and turned into bits by a
  // concatenation, so no product can wrap in a narrow context.
  wire [3:0]   total_bytes = 4'h1 + {1'b0, cmd_tx_len} + cmd_rx_len; // Opcode, sent and answer bytes.
  wire [6:0]   total_bits  = {total_bytes, 3'h0};
  wire [2:0]   tx_pad      = 3'h4 - cmd_tx_len;                      // Unused leading data bytes.
  wire [5:0]   tx_shift    = {tx_pad, 3'h0};
  wire         take       = cmd_valid & cmd_ready;

  assign cmd_ready = (state_reg == sfepic_pkg::HS_IDLE);

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // Select rises on the falling edge of the last bit, so erase and sleep
  // frames end exactly after their eighth bit. After a wake opcode the
  // longer wake gap covers both wake forms.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg     <= sfepic_pkg::HS_IDLE;
      div_reg       <= 16'h0;
      gap_reg       <= 32'h0;
      bits_left_reg <= 7'h00;
      rx_bits_reg   <= 7'h00;
      tx_sr_reg     <= 40'h0;
      rx_sr_reg     <= 64'h0;
      wake_op_reg   <= 1'b0;
      sclk_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      rsp_valid     <= 1'b0;
      rsp_data      <= 64'h0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        sfepic_pkg::HS_IDLE: begin
          if (take) begin
            state_reg     <= sfepic_pkg::HS_SHIFT;
            tx_sr_reg     <= {cmd_opcode, cmd_tx_data << tx_shift};
            bits_left_reg <= total_bits;
            rx_bits_reg   <= 7'({cmd_rx_len, 3'h0});
            rx_sr_reg     <= 64'h0;
            wake_op_reg   <= (cmd_opcode == sfepic_pkg::OP_WAKE_IDENT);
            cs_n_reg      <= 1'b0;
            div_reg       <= HALF_LOAD;
          end
        end
        sfepic_pkg::HS_SHIFT: begin
          if (!phase_end) begin
            div_reg <= div_reg - 16'h1;
          end else if (!sclk_reg) begin
            // Rising edge: the device samples; capture answer bits.
            sclk_reg <= 1'b1;
            div_reg  <= HALF_LOAD;
            if (bits_left_reg <= rx_bits_reg) begin
              rx_sr_reg <= {rx_sr_reg[62:0], spi.miso};
            end
          end else begin
            // Falling edge: next bit out, or end of frame.
            sclk_reg      <= 1'b0;
            div_reg       <= HALF_LOAD;
            tx_sr_reg     <= {tx_sr_reg[38:0], 1'b0};
            bits_left_reg <= bits_left_reg - 7'h01;
            if (bits_left_reg == 7'h01) begin
              cs_n_reg  <= 1'b1;
              gap_reg   <= wake_op_reg ? WAKE_LOAD : GAP_LOAD;
              state_reg <= sfepic_pkg::HS_GAP;
            end
          end
        end
        sfepic_pkg::HS_GAP: begin
          if (gap_reg == 32'h0) begin
            state_reg <= sfepic_pkg::HS_IDLE;
            rsp_valid <= 1'b1;
            rsp_data  <= rx_sr_reg;
          end else begin
            gap_reg <= gap_reg - 32'h1;
          end
        end
        default: begin
          state_reg <= sfepic_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Link outputs
  // ****************************************************************
  assign spi.cs_n = cs_n_reg;
  assign spi.sclk = sclk_reg;
  assign spi.mosi = tx_sr_reg[39];

endmodule

// file: tb/sfepic_chk_assertions.sv
/* Link and status checks for the flash command path.
   Assumes the bench ties each input to its signal. */
`timescale 1ns/1ps
module sfepic_chk_assertions (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       mosi,
  input wire logic       miso,
  // Device status
  input wire logic [2:0] block_protect_bits,
  input wire logic       write_enable_latch,
  input wire logic       busy,
  input wire logic       sleeping,
  input wire logic       erase_done
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sclk_idle_a: assert property (cs_n |-> !sclk) else $error("clock moved idle");
  mosi_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi)) else $error("data moved");
  miso_idle_a: assert property (cs_n && $past(cs_n) |-> !miso) else $error("data out idle");
  erase_wel_a: assert property ($rose(busy) |-> $past(write_enable_latch)) else $error("no latch");
  erase_prot_a: assert property ($rose(busy) |-> $past(block_protect_bits) == 3'h0) else $error("prot");
  erase_cs_a: assert property ($rose(busy) |-> cs_n) else $error("erase in frame");
  erase_len_a: assert property ($rose(busy) |-> busy[*8]) else $error("erase short");
  done_wel_a: assert property (erase_done |=> !write_enable_latch && !busy) else $error("latch kept");
  sleep_busy_a: assert property (sleeping |-> !busy) else $error("busy asleep");
  sleep_cs_a: assert property ($rose(sleeping) |-> cs_n) else $error("sleep in frame");
  // Main scenarios reached.
  cover property ($rose(busy));
  cover property ($rose(sleeping));
  cover property ($fell(sleeping));
endmodule

// file: tb/test_spi_flash_erase_powerdown_id_cmds.sv
/* Bench joining host and device ends over the link.
   Assumes package, interface and both ends compile first. */
`timescale 1ns/1ps
module test_spi_flash_erase_powerdown_id_cmds;
  // Identification values, all arbitrary.
  localparam logic [7:0]  MFR = 8'h5C;
  localparam logic [7:0]  DEV = 8'h13;
  localparam logic [15:0] TC  = 16'h3114;
  localparam logic [63:0] UID = 64'hA5C31E700F964B2D;
  localparam logic [63:0] NA  = {64{1'bx}};
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready, rsp_valid, write_enable_latch, busy, sleeping, erase_done;
  logic [7:0]  cmd_opcode = 8'h00;
  logic [2:0]  cmd_tx_len = 3'h0, block_protect_bits = 3'h0, bp;
  logic [31:0] cmd_tx_data = 32'h0;
  logic [3:0]  cmd_rx_len = 4'h0;
  logic [63:0] rsp_data, want, exp_q[$];
  logic [7:0]  ops[2] = '{8'hC7, 8'h60};
  int          num_errors = 0, checks_done = 0, erase_seen = 0;
  sfepic_spi_if link ();
  always #2 clk_sys = ~clk_sys;
  sfepic_host sfepic_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_opcode(cmd_opcode), .cmd_tx_len(cmd_tx_len), .cmd_tx_data(cmd_tx_data), .cmd_rx_len(cmd_rx_len),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spi(link));
  // Erase shortened so the run stays brief.
  sfepic_device #(.ERASE_CYCLES(400), .MFR_ID(MFR), .DEVICE_ID(DEV), .MEM_TYPE(TC[15:8]), .CAPACITY(TC[7:0]),
    .UNIQUE_ID(UID)) sfepic_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .spi(link), .busy(busy),
    .block_protect_bits(block_protect_bits), .write_enable_latch(write_enable_latch), .sleeping(sleeping),
    .erase_done(erase_done));
  sfepic_chk_assertions sfepic_chk_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .block_protect_bits(block_protect_bits),
    .write_enable_latch(write_enable_latch), .busy(busy), .sleeping(sleeping), .erase_done(erase_done));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Notes the answer, then holds the request until it is taken.
  task automatic send(input logic [7:0] o, input logic [2:0] tl, input logic [31:0] td, input logic [3:0] rl,
                      input logic [63:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_sys);
    cmd_valid   <= 1'b1;
    cmd_opcode  <= o;
    cmd_tx_len  <= tl;
    cmd_tx_data <= td;
    cmd_rx_len  <= rl;
    @(negedge clk_sys);
    while (!cmd_ready) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask
  task automatic stat(input logic [2:0] p, input logic w, input logic b);
    send(8'h05, 3'h0, 32'h0, 4'h1, 64'({p, w, b}));
  endtask
  task automatic op(input logic [7:0] o);
    send(o, 3'h0, 32'h0, 4'h0, NA);
  endtask
  task automatic drain(input string name);
    @(negedge clk_sys);
    while (!cmd_ready || exp_q.size() != 0) @(negedge clk_sys);
    @(posedge clk_sys);
    $display("test %s done", name);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Each answer is matched with the oldest note.
  always @(posedge clk_sys) begin
    if (rsp_valid) begin
      want = exp_q.pop_front();
      if (want !== NA) check(rsp_data, want);
    end
    if (erase_done) erase_seen++;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h19907B6F));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    stat(3'h0, 1'b0, 1'b0);
    send(8'h9F, 3'h0, 32'h0, 4'h3, {40'h0, MFR, TC});
    send(8'h90, 3'h3, 32'h0, 4'h4, {32'h0, MFR, DEV, MFR, DEV});
    send(8'h90, 3'h3, 32'h1, 4'h3, {40'h0, DEV, MFR, DEV});
    send(8'h4B, 3'h4, $urandom, 4'h8, UID);
    send(8'hAB, 3'h3, $urandom, 4'h3, {40'h0, DEV, DEV, DEV});
    drain("ident");
    foreach (ops[i]) begin
      bp = 3'h1 + 3'($urandom % 7);
      op(ops[i]);
      stat(3'h0, 1'b0, 1'b0);
      op(8'h06);
      drain("latch");
      check(64'(write_enable_latch), 64'h1);
      block_protect_bits <= bp;
      op(ops[i]);
      stat(bp, 1'b1, 1'b0);
      drain("protect");
      block_protect_bits <= 3'h0;
      send(ops[i], 3'h1, $urandom, 4'h0, NA);
      stat(3'h0, 1'b1, 1'b0);
      op(ops[i]);
      stat(3'h0, 1'b1, 1'b1);
      send(8'hAB, 3'h3, 32'h0, 4'h1, 64'h0);
      stat(3'h0, 1'b0, 1'b0);
      drain("erase");
    end
    block_protect_bits <= bp;
    op(8'hB9);
    send(8'h05, 3'h0, 32'h0, 4'h1, 64'h0);
    drain("entry");
    repeat (sfepic_pkg::SLEEP_CYCLES) @(posedge clk_sys);
    check(64'(sleeping), 64'h1);
    send(8'h05, 3'h0, 32'h0, 4'h1, 64'h0);
    op(8'hAB);
    stat(bp, 1'b0, 1'b0);
    op(8'hB9);
    send(8'hAB, 3'h3, $urandom, 4'h2, {48'h0, DEV, DEV});
    stat(bp, 1'b0, 1'b0);
    drain("sleep");
    check(64'(erase_seen), 64'h2);
    wrap_up();
  end
endmodule
